// ---- rtl/uv_filter.sv ----
// one supply undervoltage detector with detect and recovery filters
// assumes a synchronised below-threshold level on the core clock
`timescale 1ns/1ps
module uv_filter #(
	parameter int DET_CYC = xcvr_pkg::UV_DETECT_CYC,
	parameter int REC_CYC = xcvr_pkg::UV_RECOVER_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// supply level and control
	input wire logic below,
	input wire logic restart,
	// flag and events
	output logic flag,
	output logic set_pulse,
	output logic recover_pulse
);
	localparam int CW = $clog2((DET_CYC > REC_CYC ? DET_CYC : REC_CYC) + 1);

	logic [CW-1:0] cnt;

	// a new detection wins over a restart in the same cycle
	assign set_pulse = below && !flag && cnt == CW'(DET_CYC - 1);
	assign recover_pulse = !below && flag && cnt == CW'(REC_CYC - 1);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
			cnt <= '0;
		end else if (set_pulse) begin
			flag <= 1'b1;
			cnt <= '0;
		end else if (restart || recover_pulse) begin
			flag <= 1'b0;
			cnt <= '0;
		end else if (below != flag) begin
			cnt <= cnt + 1'b1;
		end else begin
			cnt <= '0;
		end
	end
endmodule // uv_filter

// ---- rtl/xcvr_flag_ctrl.sv ----
// flag keeping, forced mode changes and transmit gating of the bus transceiver
// assumes pins arrive asynchronously; APB master on the core clock
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module xcvr_flag_ctrl #(
	parameter int TX_ACTIVE_LIMIT_CYC = xcvr_pkg::TRANSMIT_ACTIVE_LIMIT_CYC,
	parameter int UV_DETECT_CYC = xcvr_pkg::UV_DETECT_CYC,
	parameter int UV_RECOVER_CYC = xcvr_pkg::UV_RECOVER_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// apb
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host pins
	input wire logic mode_select_low,
	input wire logic mode_enable,
	input wire logic transmit_enable_low,
	input wire logic guardian_enable,
	input wire logic transmit_data,
	// wake, bus and monitors
	input wire logic wake_low,
	input wire logic remote_wake,
	input wire logic bus_data,
	input wire logic over_temp_warn,
	input wire logic over_temp_shutdown,
	input wire logic bat_below,
	input wire logic core_below,
	input wire logic io_below,
	input wire logic supply_ok,
	// outputs
	output xcvr_pkg::bus_symbol_t tx_symbol,
	output logic receiver_enable,
	output logic error_flag,
	output logic wake_flag,
	output xcvr_pkg::op_mode_t op_mode
);
	localparam int NPIN = 14;
	localparam int TOW = $clog2(TX_ACTIVE_LIMIT_CYC + 1);
	localparam int GSW = $clog2(xcvr_pkg::GO_SLEEP_CYC + 1);

	function automatic logic is_lp(input xcvr_pkg::op_mode_t m);
		return m == xcvr_pkg::MODE_STANDBY || m == xcvr_pkg::MODE_GO_SLEEP ||
			m == xcvr_pkg::MODE_SLEEP;
	endfunction

	function automatic logic is_np(input xcvr_pkg::op_mode_t m);
		return m == xcvr_pkg::MODE_NORMAL || m == xcvr_pkg::MODE_RX_ONLY;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		return a == xcvr_pkg::ADDR_STATUS || a == xcvr_pkg::ADDR_MODE ||
			a == xcvr_pkg::ADDR_CTRL;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [NPIN-1:0] pin_raw, pin_meta, pin_sync;
	logic stb, en, tel, guard_ok, txd, wkl, rwk, bdat, hot_w, hot_s, bat_lo, core_lo, io_lo, sup;

	assign pin_raw = {supply_ok, io_below, core_below, bat_below, over_temp_shutdown,
		over_temp_warn, bus_data, remote_wake, wake_low, transmit_data, guardian_enable,
		transmit_enable_low, mode_enable, mode_select_low};
	// idle levels at reset so no false wake or enable edge appears
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= xcvr_pkg::PIN_RESET;
			pin_sync <= xcvr_pkg::PIN_RESET;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end
	assign {sup, io_lo, core_lo, bat_lo, hot_s, hot_w, bdat, rwk, wkl, txd, guard_ok, tel, en, stb}
		= pin_sync;

	// ----------------------------------------
	// state and edges
	// ----------------------------------------
	xcvr_pkg::op_mode_t mode, next_mode, prev_mode, pin_mode, next_pin_mode;
	logic local_wake, remote_wake_f, wake, power_on, therm_warn, therm_sd, tx_timeout, bus_err;
	logic local_q, remote_q, tel_q, txd_q, sup_q, pin_ctrl_en, tx_armed, tx_started, cmp_pending;
	logic tx_inhibit, status_rd, any_fault, tx_enabled;
	logic uv_bat, uv_core, uv_io, bat_set, core_set, io_set, bat_rec;
	logic [TOW-1:0] to_cnt;
	logic [GSW-1:0] gs_cnt;

	wire lp_entry = is_lp(mode) && !is_lp(prev_mode);
	wire normal_entry = mode == xcvr_pkg::MODE_NORMAL && prev_mode != xcvr_pkg::MODE_NORMAL;
	wire wake_rise = (local_wake && !local_q) || (remote_wake_f && !remote_q);
	wire uv_any_set = bat_set || core_set || io_set;
	wire uv_restart = wake_rise || bat_rec;
	wire tel_fall = tel_q && !tel;
	wire np = is_np(mode);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_mode <= xcvr_pkg::MODE_STANDBY;
			local_q <= 1'b0;
			remote_q <= 1'b0;
			tel_q <= 1'b1;
			txd_q <= 1'b0;
			sup_q <= 1'b0;
		end else begin
			prev_mode <= mode;
			local_q <= local_wake;
			remote_q <= remote_wake_f;
			tel_q <= tel;
			txd_q <= txd;
			sup_q <= sup;
		end
	end

	// ----------------------------------------
	// undervoltage detectors
	// ----------------------------------------
	uv_filter #(.DET_CYC(UV_DETECT_CYC), .REC_CYC(UV_RECOVER_CYC)) u_bat (
		.clock(clock), .rst_n(rst_n), .below(bat_lo), .restart(uv_restart),
		.flag(uv_bat), .set_pulse(bat_set), .recover_pulse(bat_rec));
	uv_filter #(.DET_CYC(UV_DETECT_CYC), .REC_CYC(UV_RECOVER_CYC)) u_core (
		.clock(clock), .rst_n(rst_n), .below(core_lo), .restart(uv_restart),
		.flag(uv_core), .set_pulse(core_set), .recover_pulse());
	uv_filter #(.DET_CYC(UV_DETECT_CYC), .REC_CYC(UV_RECOVER_CYC)) u_io (
		.clock(clock), .rst_n(rst_n), .below(io_lo), .restart(uv_restart),
		.flag(uv_io), .set_pulse(io_set), .recover_pulse());

	// ----------------------------------------
	// pin mode control
	// ----------------------------------------
	// keeps running while pins are ignored, so a sleep request survives
	always_comb begin
		next_pin_mode = pin_mode;
		case ({stb, en})
			2'b11: next_pin_mode = xcvr_pkg::MODE_NORMAL;
			2'b10: next_pin_mode = xcvr_pkg::MODE_RX_ONLY;
			2'b01: begin
				if (pin_mode == xcvr_pkg::MODE_SLEEP ||
					(pin_mode == xcvr_pkg::MODE_GO_SLEEP && gs_cnt == GSW'(xcvr_pkg::GO_SLEEP_CYC - 1)))
					next_pin_mode = xcvr_pkg::MODE_SLEEP;
				else
					next_pin_mode = xcvr_pkg::MODE_GO_SLEEP;
			end
			2'b00: begin
				if (pin_mode != xcvr_pkg::MODE_SLEEP)
					next_pin_mode = xcvr_pkg::MODE_STANDBY;
			end
			default: next_pin_mode = pin_mode;
		endcase
		if (wake_rise)
			next_pin_mode = xcvr_pkg::MODE_STANDBY;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_mode <= xcvr_pkg::MODE_STANDBY;
			gs_cnt <= '0;
		end else begin
			pin_mode <= next_pin_mode;
			gs_cnt <= (pin_mode == xcvr_pkg::MODE_GO_SLEEP) ? gs_cnt + 1'b1 : '0;
		end
	end

	// ----------------------------------------
	// forced mode changes
	// ----------------------------------------
	always_comb begin
		next_mode = mode;
		if (bat_set || io_set)
			next_mode = xcvr_pkg::MODE_SLEEP;
		else if (core_set && mode != xcvr_pkg::MODE_SLEEP)
			next_mode = xcvr_pkg::MODE_STANDBY;
		else if (wake_rise)
			next_mode = xcvr_pkg::MODE_STANDBY;
		else if (pin_ctrl_en)
			next_mode = next_pin_mode;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode <= xcvr_pkg::MODE_STANDBY;
			pin_ctrl_en <= 1'b1;
			receiver_enable <= 1'b0;
		end else begin
			mode <= next_mode;
			receiver_enable <= is_np(next_mode);
			if (uv_any_set)
				pin_ctrl_en <= 1'b0;
			else if (bat_rec)
				pin_ctrl_en <= 1'b1;
			else if (!uv_bat && !uv_core && !uv_io)
				pin_ctrl_en <= 1'b1;
		end
	end
	assign op_mode = mode;

	// ----------------------------------------
	// wake and power flags
	// ----------------------------------------
	// each set term is tested first so a same-cycle clear cannot lose it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			local_wake <= 1'b0;
			remote_wake_f <= 1'b0;
			wake <= 1'b0;
			power_on <= 1'b1;
		end else begin
			if (!wkl && is_lp(mode))
				local_wake <= 1'b1;
			else if (lp_entry)
				local_wake <= 1'b0;
			if (rwk && is_lp(mode))
				remote_wake_f <= 1'b1;
			else if (lp_entry)
				remote_wake_f <= 1'b0;
			if (wake_rise)
				wake <= 1'b1;
			else if (normal_entry || lp_entry || uv_any_set)
				wake <= 1'b0;
			if (sup && !sup_q)
				power_on <= 1'b1;
			else if (normal_entry)
				power_on <= 1'b0;
		end
	end

	// ----------------------------------------
	// thermal flags
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			therm_warn <= 1'b0;
			therm_sd <= 1'b0;
		end else begin
			if (hot_w && np && !uv_bat)
				therm_warn <= 1'b1;
			else if (((!hot_w && np) || (status_rd && is_lp(mode))) && !uv_bat)
				therm_warn <= 1'b0;
			if (hot_s && np && !uv_bat)
				therm_sd <= 1'b1;
			else if (!hot_s && np && tel_fall && !uv_bat)
				therm_sd <= 1'b0;
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	assign tx_enabled = mode == xcvr_pkg::MODE_NORMAL && guard_ok && !tel && tx_started &&
		!therm_sd && !tx_timeout && !tx_inhibit;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_armed <= 1'b0;
			tx_started <= 1'b0;
		end else if (tel || mode != xcvr_pkg::MODE_NORMAL) begin
			tx_armed <= 1'b0;
			tx_started <= 1'b0;
		end else begin
			if (tel_fall)
				tx_armed <= 1'b1;
			if ((tx_armed || tel_fall) && !txd)
				tx_started <= 1'b1;
		end
	end

	// timeout counts enable-low time in Normal, whatever the guardian does
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			to_cnt <= '0;
			tx_timeout <= 1'b0;
		end else if (tel || mode != xcvr_pkg::MODE_NORMAL) begin
			to_cnt <= '0;
			tx_timeout <= 1'b0;
		end else if (to_cnt == TOW'(TX_ACTIVE_LIMIT_CYC - 1)) begin
			tx_timeout <= 1'b1;
		end else begin
			to_cnt <= to_cnt + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_symbol <= xcvr_pkg::SYM_LOW_POWER_IDLE;
		end else if (is_lp(next_mode)) begin
			tx_symbol <= xcvr_pkg::SYM_LOW_POWER_IDLE;
		end else if (next_mode == xcvr_pkg::MODE_RX_ONLY || !tx_enabled) begin
			tx_symbol <= xcvr_pkg::SYM_IDLE;
		end else begin
			tx_symbol <= txd ? xcvr_pkg::SYM_DATA1 : xcvr_pkg::SYM_DATA0;
		end
	end

	// ----------------------------------------
	// bus error check
	// ----------------------------------------
	// bus data sampled one cycle after the data edge to let the loop settle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmp_pending <= 1'b0;
			bus_err <= 1'b0;
		end else begin
			cmp_pending <= tx_enabled && (txd != txd_q);
			if (!tx_enabled)
				bus_err <= 1'b0;
			else if (cmp_pending)
				bus_err <= bdat != txd;
		end
	end

	// ----------------------------------------
	// error summary
	// ----------------------------------------
	assign any_fault = bus_err || therm_warn || therm_sd || tx_timeout || uv_bat || uv_core || uv_io;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			error_flag <= 1'b0;
		end else begin
			error_flag <= any_fault;
		end
	end
	assign wake_flag = wake;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	wire access = psel && penable;
	assign pready = 1'b1;
	assign pslverr = access && !mapped(paddr);
	assign status_rd = access && !pwrite && paddr == xcvr_pkg::ADDR_STATUS;

	// read data captured in the setup cycle, stable through the access
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			case (paddr)
				xcvr_pkg::ADDR_STATUS: prdata[xcvr_pkg::ST_ERROR:0] <= {error_flag, uv_io, uv_core,
					uv_bat, bus_err, tx_timeout, therm_sd, therm_warn, power_on, wake,
					remote_wake_f, local_wake};
				xcvr_pkg::ADDR_MODE: prdata[xcvr_pkg::MD_PIN_CTRL:0] <= {pin_ctrl_en, mode};
				xcvr_pkg::ADDR_CTRL: prdata[xcvr_pkg::CTRL_TX_INHIBIT] <= tx_inhibit;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			tx_inhibit <= xcvr_pkg::CTRL_TX_INHIBIT_RESET;
		else if (access && pwrite && paddr == xcvr_pkg::ADDR_CTRL)
			tx_inhibit <= pwdata[xcvr_pkg::CTRL_TX_INHIBIT];
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_wake_rise;
		wake_rise && !uv_any_set;
	endsequence
	sequence s_standby_clean;
		mode == xcvr_pkg::MODE_STANDBY && !uv_bat && !uv_core && !uv_io;
	endsequence

	property p_lp_clears_local;
		lp_entry && wkl |=> !local_wake;
	endproperty
	a_lp_clears_local: assert property (p_lp_clears_local) else $error("local wake kept");
	property p_wake_clr;
		normal_entry && !wake_rise |=> !wake;
	endproperty
	a_wake_clr: assert property (p_wake_clr) else $error("wake kept in normal");
	property p_power_on;
		normal_entry && !(sup && !sup_q) |=> !power_on;
	endproperty
	a_power_on: assert property (p_power_on) else $error("power-on kept");
	property p_timeout;
		mode == xcvr_pkg::MODE_NORMAL && !tel && next_mode == xcvr_pkg::MODE_NORMAL &&
			to_cnt == TOW'(TX_ACTIVE_LIMIT_CYC - 1) |=> tx_timeout ##1
			(tx_symbol != xcvr_pkg::SYM_DATA0 && tx_symbol != xcvr_pkg::SYM_DATA1);
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout missed");
	property p_sd_blocks;
		therm_sd |=> tx_symbol != xcvr_pkg::SYM_DATA0 && tx_symbol != xcvr_pkg::SYM_DATA1;
	endproperty
	a_sd_blocks: assert property (p_sd_blocks) else $error("driving in shutdown");
	property p_error;
		any_fault [*2] |-> error_flag;
	endproperty
	a_error: assert property (p_error) else $error("error flag low");
	property p_bat_sleep;
		bat_set || io_set |=> mode == xcvr_pkg::MODE_SLEEP && !pin_ctrl_en;
	endproperty
	a_bat_sleep: assert property (p_bat_sleep) else $error("no forced sleep");
	property p_core_standby;
		core_set && !bat_set && !io_set && mode != xcvr_pkg::MODE_SLEEP |=>
			mode == xcvr_pkg::MODE_STANDBY;
	endproperty
	a_core_standby: assert property (p_core_standby) else $error("no forced standby");
	property p_wake_standby;
		s_wake_rise |=> s_standby_clean;
	endproperty
	a_wake_standby: assert property (p_wake_standby) else $error("wake not standby");
	property p_rx;
		is_np(mode) == receiver_enable;
	endproperty
	a_rx: assert property (p_rx) else $error("receiver enable wrong");
	property p_lp_sym;
		is_lp(mode) |-> tx_symbol == xcvr_pkg::SYM_LOW_POWER_IDLE;
	endproperty
	a_lp_sym: assert property (p_lp_sym) else $error("symbol in low power");
	property p_first_zero;
		$rose(tx_started) |-> !$past(txd);
	endproperty
	a_first_zero: assert property (p_first_zero) else $error("start on data one");
endmodule // xcvr_flag_ctrl

// ---- rtl/xcvr_pkg.sv ----
// constants, modes and bus symbols of the transceiver flag control
// assumes a 40 MHz core clock and an APB register port
package xcvr_pkg;

	// ----------------------------------------
	// modes and symbols
	// ----------------------------------------
	typedef enum logic [2:0] {MODE_NORMAL, MODE_RX_ONLY, MODE_STANDBY, MODE_GO_SLEEP,
		MODE_SLEEP} op_mode_t;
	typedef enum logic [1:0] {SYM_LOW_POWER_IDLE, SYM_IDLE, SYM_DATA0, SYM_DATA1} bus_symbol_t;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLOCK_MHZ = 40;
	localparam real TRANSMIT_ACTIVE_LIMIT_MS = 1.5;
	localparam int TRANSMIT_ACTIVE_LIMIT_CYC = int'(TRANSMIT_ACTIVE_LIMIT_MS * 1000.0) * CLOCK_MHZ;
	localparam int UV_DETECT_US = 10;
	localparam int UV_RECOVER_US = 50;
	localparam int UV_DETECT_CYC = UV_DETECT_US * CLOCK_MHZ;
	localparam int UV_RECOVER_CYC = UV_RECOVER_US * CLOCK_MHZ;
	localparam int GO_SLEEP_US = 2;
	localparam int GO_SLEEP_CYC = GO_SLEEP_US * CLOCK_MHZ;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_MODE = 12'h004;
	localparam logic [11:0] ADDR_CTRL = 12'h008;
	localparam int ST_LOCAL_WAKE = 0;
	localparam int ST_REMOTE_WAKE = 1;
	localparam int ST_WAKE = 2;
	localparam int ST_POWER_ON = 3;
	localparam int ST_THERM_WARN = 4;
	localparam int ST_THERM_SD = 5;
	localparam int ST_TX_TIMEOUT = 6;
	localparam int ST_BUS_ERR = 7;
	localparam int ST_UV_BAT = 8;
	localparam int ST_UV_CORE = 9;
	localparam int ST_UV_IO = 10;
	localparam int ST_ERROR = 11;
	localparam int MD_PIN_CTRL = 3;
	localparam int CTRL_TX_INHIBIT = 0;
	localparam logic CTRL_TX_INHIBIT_RESET = 1'b0;
	localparam logic [13:0] PIN_RESET = 14'h0024;

endpackage

// ---- verification/bus_partner.sv ----
// protocol controller and bus line model facing the transceiver flag control
// assumes bench commands change right after a rising clock edge
`timescale 1ns/1ps
module bus_partner (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// bench commands
	input wire logic tx_request,
	input wire logic tx_bit,
	input wire logic corrupt,
	// device side
	input wire xcvr_pkg::bus_symbol_t tx_symbol,
	output logic transmit_enable_low,
	output logic transmit_data,
	output logic bus_data
);
	logic started;

	// ----------------------------------------
	// transmit pins
	// ----------------------------------------
	// first cycle of a frame always carries data zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			transmit_enable_low <= 1'b1;
			transmit_data <= 1'b0;
			started <= 1'b0;
		end else if (!tx_request) begin
			transmit_enable_low <= 1'b1;
			transmit_data <= 1'b0;
			started <= 1'b0;
		end else begin
			transmit_enable_low <= 1'b0;
			transmit_data <= started ? tx_bit : 1'b0;
			started <= 1'b1;
		end
	end
	// echo with no line delay; corrupt fakes a collision on the wire
	assign bus_data = ((tx_symbol == xcvr_pkg::SYM_DATA0 || tx_symbol == xcvr_pkg::SYM_DATA1)
		? transmit_data : 1'b1) ^ corrupt;
endmodule // bus_partner

// ---- verification/tb_xcvr_flag_ctrl.sv ----
// self-checking bench for the transceiver flag control block
// assumes the partner drives the transmit pins and echoes the line
`timescale 1ns/1ps
module tb_xcvr_flag_ctrl;
	localparam int TX_LIM = 300;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic mode_select_low = 1'b0;
	logic mode_enable = 1'b0;
	logic transmit_enable_low;
	logic guardian_enable = 1'b1;
	logic transmit_data;
	logic wake_low = 1'b1;
	logic remote_wake = 1'b0;
	logic bus_data;
	logic over_temp_warn = 1'b0;
	logic over_temp_shutdown = 1'b0;
	logic bat_below = 1'b0;
	logic core_below = 1'b0;
	logic io_below = 1'b0;
	logic supply_ok = 1'b1;
	logic tx_request = 1'b0;
	logic tx_bit = 1'b0;
	logic corrupt = 1'b0;
	xcvr_pkg::bus_symbol_t tx_symbol;
	logic receiver_enable;
	logic error_flag;
	logic wake_flag;
	xcvr_pkg::op_mode_t op_mode;
	logic [31:0] rd;
	logic err;
	int err_total = 0;
	int total_checks = 0;

	xcvr_flag_ctrl #(.TX_ACTIVE_LIMIT_CYC(TX_LIM), .UV_DETECT_CYC(5), .UV_RECOVER_CYC(8)) dut (
		.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.mode_select_low, .mode_enable, .transmit_enable_low, .guardian_enable, .transmit_data,
		.wake_low, .remote_wake, .bus_data, .over_temp_warn, .over_temp_shutdown, .bat_below,
		.core_below, .io_below, .supply_ok, .tx_symbol, .receiver_enable, .error_flag,
		.wake_flag, .op_mode);
	bus_partner partner (.clock, .rst_n, .tx_request, .tx_bit, .corrupt, .tx_symbol,
		.transmit_enable_low, .transmit_data, .bus_data);

	always #12.5 clock = ~clock;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic flag(input logic seen, input logic e);
		check({31'h0, seen}, {31'h0, e});
	endtask
	task automatic sym(input xcvr_pkg::bus_symbol_t s);
		check({30'h0, tx_symbol}, {30'h0, s});
	endtask
	// waits up to 20 cycles for pready, so a slave latency below that is accepted
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			results();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// callers compare outputs only once they have settled
		@(negedge clock);
	endtask
	task automatic st_bit(input int i, input logic e);
		apb(1'b0, xcvr_pkg::ADDR_STATUS, 32'h0000_0000);
		flag(rd[i], e);
	endtask
	task automatic settle();
		repeat (6) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic wait_mode(input xcvr_pkg::op_mode_t m);
		int n;
		n = 0;
		while (op_mode !== m && n < 300) begin
			@(negedge clock);
			n++;
		end
		check({29'h0, op_mode}, {29'h0, m});
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (100000) @(posedge clock);
		err_total++;
		results();
	end
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		apb(1'b0, xcvr_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0008);
		sym(xcvr_pkg::SYM_LOW_POWER_IDLE);
		flag(receiver_enable, 1'b0);
		apb(1'b1, xcvr_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		check({rd[30:0], err}, 32'h0000_0001);
		apb(1'b0, xcvr_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0008);
		apb(1'b0, xcvr_pkg::ADDR_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		$display("reset test done");
		@(posedge clock) mode_select_low <= 1'b1;
		wait_mode(xcvr_pkg::MODE_RX_ONLY);
		flag(receiver_enable, 1'b1);
		@(posedge clock) tx_request <= 1'b1;
		settle();
		sym(xcvr_pkg::SYM_IDLE);
		@(posedge clock) mode_enable <= 1'b1;
		wait_mode(xcvr_pkg::MODE_NORMAL);
		settle();
		sym(xcvr_pkg::SYM_IDLE);
		st_bit(xcvr_pkg::ST_POWER_ON, 1'b0);
		@(posedge clock) tx_request <= 1'b0;
		settle();
		@(posedge clock) tx_request <= 1'b1;
		settle();
		sym(xcvr_pkg::SYM_DATA0);
		@(posedge clock) tx_bit <= 1'b1;
		settle();
		sym(xcvr_pkg::SYM_DATA1);
		@(posedge clock) guardian_enable <= 1'b0;
		settle();
		sym(xcvr_pkg::SYM_IDLE);
		@(posedge clock) guardian_enable <= 1'b1;
		apb(1'b1, xcvr_pkg::ADDR_CTRL, 32'h0000_0001);
		apb(1'b0, xcvr_pkg::ADDR_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0001);
		apb(1'b1, xcvr_pkg::ADDR_CTRL, 32'h0000_0000);
		$display("transmit test done");
		@(posedge clock) corrupt <= 1'b1;
		tx_bit <= 1'b0;
		settle();
		st_bit(xcvr_pkg::ST_BUS_ERR, 1'b1);
		flag(error_flag, 1'b1);
		@(posedge clock) corrupt <= 1'b0;
		tx_bit <= 1'b1;
		settle();
		st_bit(xcvr_pkg::ST_BUS_ERR, 1'b0);
		flag(error_flag, 1'b0);
		@(posedge clock) over_temp_warn <= 1'b1;
		settle();
		st_bit(xcvr_pkg::ST_THERM_WARN, 1'b1);
		sym(xcvr_pkg::SYM_DATA1);
		@(posedge clock) over_temp_warn <= 1'b0;
		settle();
		st_bit(xcvr_pkg::ST_THERM_WARN, 1'b0);
		@(posedge clock) over_temp_shutdown <= 1'b1;
		settle();
		sym(xcvr_pkg::SYM_IDLE);
		@(posedge clock) over_temp_shutdown <= 1'b0;
		settle();
		st_bit(xcvr_pkg::ST_THERM_SD, 1'b1);
		@(posedge clock) tx_request <= 1'b0;
		settle();
		@(posedge clock) tx_request <= 1'b1;
		settle();
		st_bit(xcvr_pkg::ST_THERM_SD, 1'b0);
		sym(xcvr_pkg::SYM_DATA1);
		repeat (TX_LIM) @(posedge clock);
		settle();
		sym(xcvr_pkg::SYM_IDLE);
		st_bit(xcvr_pkg::ST_TX_TIMEOUT, 1'b1);
		@(posedge clock) tx_request <= 1'b0;
		settle();
		st_bit(xcvr_pkg::ST_TX_TIMEOUT, 1'b0);
		$display("fault flag test done");
		@(posedge clock) core_below <= 1'b1;
		wait_mode(xcvr_pkg::MODE_STANDBY);
		st_bit(xcvr_pkg::ST_UV_CORE, 1'b1);
		@(posedge clock) core_below <= 1'b0;
		wait_mode(xcvr_pkg::MODE_NORMAL);
		st_bit(xcvr_pkg::ST_UV_CORE, 1'b0);
		@(posedge clock) bat_below <= 1'b1;
		wait_mode(xcvr_pkg::MODE_SLEEP);
		st_bit(xcvr_pkg::ST_UV_BAT, 1'b1);
		@(posedge clock) bat_below <= 1'b0;
		wait_mode(xcvr_pkg::MODE_NORMAL);
		$display("supply test done");
		@(posedge clock) over_temp_warn <= 1'b1;
		settle();
		@(posedge clock) mode_select_low <= 1'b0;
		wait_mode(xcvr_pkg::MODE_SLEEP);
		st_bit(xcvr_pkg::ST_THERM_WARN, 1'b1);
		st_bit(xcvr_pkg::ST_THERM_WARN, 1'b0);
		@(posedge clock) over_temp_warn <= 1'b0;
		@(posedge clock) wake_low <= 1'b0;
		wait_mode(xcvr_pkg::MODE_STANDBY);
		flag(wake_flag, 1'b1);
		st_bit(xcvr_pkg::ST_LOCAL_WAKE, 1'b1);
		@(posedge clock) wake_low <= 1'b1;
		mode_select_low <= 1'b1;
		wait_mode(xcvr_pkg::MODE_NORMAL);
		settle();
		flag(wake_flag, 1'b0);
		$display("wake test done");
		@(posedge clock) mode_select_low <= 1'b0;
		wait_mode(xcvr_pkg::MODE_SLEEP);
		@(posedge clock) mode_enable <= 1'b0;
		settle();
		@(posedge clock) io_below <= 1'b1;
		settle();
		st_bit(xcvr_pkg::ST_UV_IO, 1'b1);
		flag(error_flag, 1'b1);
		@(posedge clock) io_below <= 1'b0;
		settle();
		settle();
		st_bit(xcvr_pkg::ST_UV_IO, 1'b0);
		apb(1'b0, xcvr_pkg::ADDR_MODE, 32'h0000_0000);
		check(rd, {28'h0, 1'b1, xcvr_pkg::MODE_SLEEP});
		@(posedge clock) remote_wake <= 1'b1;
		wait_mode(xcvr_pkg::MODE_STANDBY);
		flag(wake_flag, 1'b1);
		st_bit(xcvr_pkg::ST_REMOTE_WAKE, 1'b1);
		$display("undervoltage mode test done");
		results();
	end
endmodule // tb_xcvr_flag_ctrl
